// file: design/timer_pkg.sv
// Purpose: Shared constants for the eight-bit timer block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses
package timer_pkg;
  localparam int          ADDR_W      = 6;
  localparam int          NUM_CH      = 2;
  // Register offsets
  localparam logic [5:0]  CH_STRIDE   = 6'h10;
  localparam logic [3:0]  CTRL_OFF    = 4'h0;
  localparam logic [3:0]  CMP_OFF     = 4'h4;
  localparam logic [3:0]  CNT_OFF     = 4'h8;
  localparam logic [5:0]  GLOBAL_BASE = 6'h20;
  localparam logic [5:0]  CFG_OFF     = 6'h20;
  localparam logic [5:0]  STAT_OFF    = 6'h24;
  localparam logic [5:0]  MASK_OFF    = 6'h28;
  // Control field positions
  localparam int          MODE_LSB    = 0;
  localparam int          MODE_MSB    = 2;
  localparam int          RUN_BIT     = 3;
  localparam int          CK_LSB      = 4;
  localparam int          CK_MSB      = 6;
  localparam int          PRESET_BIT  = 7;
  // Config field positions
  localparam int          CFG_TAP_BIT  = 0;
  localparam int          CFG_SLOW_BIT = 1;
  // Field encodings
  localparam logic [2:0]  MODE_TIMER   = 3'h0;
  localparam logic [2:0]  MODE_DIVIDER = 3'h1;
  localparam logic [2:0]  CK_SLOW_TAP  = 3'h0;
  localparam logic [2:0]  CK_DIV7      = 3'h1;
  localparam logic [2:0]  CK_DIV5      = 3'h2;
  localparam logic [2:0]  CK_DIV3      = 3'h3;
  localparam logic [2:0]  CK_EVENT     = 3'h4;
  // Reset values
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  CMP_RST     = 8'hff;
  localparam logic [1:0]  CFG_RST     = 2'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  // Prescaler
  localparam int          PRE_W       = 11;
  localparam int          FS_TAP_W    = 3;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: design/tick_if.sv
// Purpose: Prescaler tap pulses toward the channels
// Assumes: One clock domain
// Notes:   Each tap is a one-cycle pulse
`timescale 1ns/1ps
interface tick_if;
  logic fc_div3;
  logic fc_div5;
  logic fc_div7;
  logic fc_div11;
  logic fs_div3;
  modport src (output fc_div3, output fc_div5, output fc_div7, output fc_div11,
               output fs_div3);
  modport dst (input fc_div3, input fc_div5, input fc_div7, input fc_div11,
               input fs_div3);
endinterface

// file: design/tap_prescaler.sv
// Purpose: Divides the bus clock into fc and fs tap pulses
// Assumes: fc and fs are derived from aclk by integer ratios
// Notes:   Ratios are parameters
`timescale 1ns/1ps
module tap_prescaler #(
  parameter int FC_DIV = 1,
  parameter int FS_DIV = 305
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  tick_if.src       taps
);
  localparam int FCW = $clog2(FC_DIV + 1);
  localparam int FSW = $clog2(FS_DIV + 1);

  logic [FCW-1:0]                fc_cnt_reg;
  logic [FSW-1:0]                fs_cnt_reg;
  logic [timer_pkg::PRE_W-1:0]   fc_chain_reg;
  logic [timer_pkg::FS_TAP_W-1:0] fs_chain_reg;
  logic                          fc_pulse;
  logic                          fs_pulse;

  assign fc_pulse = (fc_cnt_reg == FCW'(FC_DIV - 1));
  assign fs_pulse = (fs_cnt_reg == FSW'(FS_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_cnt_reg <= '0;
    end else begin
      fc_cnt_reg <= fc_pulse ? '0 : fc_cnt_reg + FCW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs_cnt_reg <= '0;
    end else begin
      fs_cnt_reg <= fs_pulse ? '0 : fs_cnt_reg + FSW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_chain_reg <= '0;
      fs_chain_reg <= '0;
    end else begin
      if (fc_pulse) begin
        fc_chain_reg <= fc_chain_reg + timer_pkg::PRE_W'(1);
      end
      if (fs_pulse) begin
        fs_chain_reg <= fs_chain_reg + timer_pkg::FS_TAP_W'(1);
      end
    end
  end

  // Tap fires when all lower chain bits are ones
  assign taps.fc_div3  = fc_pulse && (&fc_chain_reg[2:0]);
  assign taps.fc_div5  = fc_pulse && (&fc_chain_reg[4:0]);
  assign taps.fc_div7  = fc_pulse && (&fc_chain_reg[6:0]);
  assign taps.fc_div11 = fc_pulse && (&fc_chain_reg[10:0]);
  assign taps.fs_div3  = fs_pulse && (&fs_chain_reg);
endmodule

// file: design/event_edge.sv
// Purpose: Synchronises the event pin and flags falling edges
// Assumes: Pin is asynchronous to aclk
// Notes:   Pulse lags the pin by two edges
`timescale 1ns/1ps
module event_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign fall_pulse = last_reg && !sync_reg;
endmodule

// file: design/timer_top.sv
// Purpose: Two eight-bit timer channels behind an AXI4-Lite slave
// Assumes: Single clock aclk, synchronous active-low reset
// Notes:   Timer, event counter and divider output modes only
`timescale 1ns/1ps
module timer_top #(
  parameter int FC_DIV = 1,
  parameter int FS_DIV = 305
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [timer_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [timer_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [timer_pkg::NUM_CH-1:0]  event_in_pin,
  output logic [timer_pkg::NUM_CH-1:0]       divider_out_pin,
  output logic [timer_pkg::NUM_CH-1:0]       match_irq,
  output logic                               irq
);
  localparam int NCH = timer_pkg::NUM_CH;

  tick_if taps ();

  logic [7:0]                   channel_control_reg [NCH];
  logic [7:0]                   compare_value_reg [NCH];
  logic [7:0]                   count_reg [NCH];
  logic [NCH-1:0]               toggle_ff_reg;
  logic [1:0]                   config_reg;
  logic [NCH-1:0]               irq_status_reg;
  logic [NCH-1:0]               irq_enable_high_reg;
  logic [NCH-1:0]               event_fall;
  logic [NCH-1:0]               tick;
  logic [NCH-1:0]               match;

  logic                         aw_held_reg;
  logic                         w_held_reg;
  logic [timer_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0]                  wdata_reg;
  logic [3:0]                   wstrb_reg;
  logic                         wr_fire;
  logic                         wr_hit;
  logic [NCH-1:0]               ctrl_wr;
  logic [NCH-1:0]               cmp_wr;
  logic                         rd_fire;
  logic                         stat_rd;

  tap_prescaler #(
    .FC_DIV (FC_DIV),
    .FS_DIV (FS_DIV)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .taps    (taps)
  );

  for (genvar g = 0; g < NCH; g++) begin : g_edge
    event_edge u_edge (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin_in     (event_in_pin[g]),
      .fall_pulse (event_fall[g])
    );
  end

  // Source tick from clock select and mode
  function automatic logic pick_tick(input logic [2:0] ck, input logic [2:0] mode,
                                     input logic tap_sel, input logic slow,
                                     input logic ev);
    logic t;
    t = 1'b0;
    if (slow) begin
      t = (ck == timer_pkg::CK_SLOW_TAP) && taps.fs_div3;
    end else begin
      case (ck)
        timer_pkg::CK_SLOW_TAP: t = tap_sel ? taps.fs_div3 : taps.fc_div11;
        timer_pkg::CK_DIV7:     t = taps.fc_div7;
        timer_pkg::CK_DIV5:     t = taps.fc_div5;
        timer_pkg::CK_DIV3:     t = taps.fc_div3;
        default:                t = 1'b0;
      endcase
    end
    if (ck == timer_pkg::CK_EVENT) begin
      t = (mode == timer_pkg::MODE_TIMER) && ev;
    end
    return t;
  endfunction

  // Channel address decode
  function automatic logic ch_hit(input logic [timer_pkg::ADDR_W-1:0] a, input int ch,
                                  input logic [3:0] off);
    return (a < timer_pkg::GLOBAL_BASE) && (a[5:4] == 2'(ch)) && (a[3:0] == off);
  endfunction

  // Tick and match per channel
  always_comb begin
    for (int j = 0; j < NCH; j++) begin
      tick[j] = channel_control_reg[j][timer_pkg::RUN_BIT] &&
                pick_tick(channel_control_reg[j][timer_pkg::CK_MSB:timer_pkg::CK_LSB],
                          channel_control_reg[j][timer_pkg::MODE_MSB:timer_pkg::MODE_LSB],
                          config_reg[timer_pkg::CFG_TAP_BIT],
                          config_reg[timer_pkg::CFG_SLOW_BIT], event_fall[j]);
      match[j] = tick[j] && (count_reg[j] + 8'h01 == compare_value_reg[j]);
    end
  end

  // Write decode
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  always_comb begin
    wr_hit = (awaddr_reg == timer_pkg::CFG_OFF) || (awaddr_reg == timer_pkg::STAT_OFF) ||
             (awaddr_reg == timer_pkg::MASK_OFF);
    for (int j = 0; j < NCH; j++) begin
      ctrl_wr[j] = wr_fire && wstrb_reg[0] && ch_hit(awaddr_reg, j, timer_pkg::CTRL_OFF);
      cmp_wr[j]  = wr_fire && wstrb_reg[0] && ch_hit(awaddr_reg, j, timer_pkg::CMP_OFF);
      wr_hit     = wr_hit || ch_hit(awaddr_reg, j, timer_pkg::CTRL_OFF) ||
                   ch_hit(awaddr_reg, j, timer_pkg::CMP_OFF) ||
                   ch_hit(awaddr_reg, j, timer_pkg::CNT_OFF);
    end
  end

  // AXI write channels
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= timer_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < NCH; j++) begin
        channel_control_reg[j] <= timer_pkg::CTRL_RST;
        compare_value_reg[j]   <= timer_pkg::CMP_RST;
      end
    end else begin
      for (int j = 0; j < NCH; j++) begin
        if (ctrl_wr[j]) begin
          channel_control_reg[j] <= wdata_reg[7:0];
        end
        if (cmp_wr[j]) begin
          compare_value_reg[j] <= wdata_reg[7:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg          <= timer_pkg::CFG_RST;
      irq_enable_high_reg <= timer_pkg::MASK_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == timer_pkg::CFG_OFF) begin
        config_reg <= wdata_reg[1:0];
      end
      if (awaddr_reg == timer_pkg::MASK_OFF) begin
        irq_enable_high_reg <= wdata_reg[NCH-1:0];
      end
    end
  end

  // Up-counter, cleared on match and while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < NCH; j++) begin
        count_reg[j] <= '0;
      end
    end else begin
      for (int j = 0; j < NCH; j++) begin
        if (!channel_control_reg[j][timer_pkg::RUN_BIT]) begin
          count_reg[j] <= '0;
        end else if (match[j]) begin
          count_reg[j] <= '0;
        end else if (tick[j]) begin
          count_reg[j] <= count_reg[j] + 8'h01;
        end
      end
    end
  end

  // Toggle flip-flop: preset on start or stopped write, held on stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_ff_reg <= '0;
    end else begin
      for (int j = 0; j < NCH; j++) begin
        if (ctrl_wr[j] && !channel_control_reg[j][timer_pkg::RUN_BIT]) begin
          toggle_ff_reg[j] <= wdata_reg[timer_pkg::PRESET_BIT];
        end else if (match[j] && channel_control_reg[j][timer_pkg::MODE_MSB:timer_pkg::MODE_LSB]
                     == timer_pkg::MODE_DIVIDER) begin
          toggle_ff_reg[j] <= !toggle_ff_reg[j];
        end
      end
    end
  end

  assign divider_out_pin = ~toggle_ff_reg;
  assign match_irq       = match;

  // Sticky status, cleared by read, set wins
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_fire && (s_axi_araddr == timer_pkg::STAT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~{NCH{stat_rd}}) | match;
    end
  end

  assign irq = |(irq_status_reg & irq_enable_high_reg);

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= timer_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= timer_pkg::RESP_SLVERR;
      if (s_axi_araddr == timer_pkg::CFG_OFF) begin
        s_axi_rdata <= {30'h0, config_reg};
        s_axi_rresp <= timer_pkg::RESP_OKAY;
      end
      if (s_axi_araddr == timer_pkg::STAT_OFF) begin
        s_axi_rdata <= {{(32-NCH){1'b0}}, irq_status_reg};
        s_axi_rresp <= timer_pkg::RESP_OKAY;
      end
      if (s_axi_araddr == timer_pkg::MASK_OFF) begin
        s_axi_rdata <= {{(32-NCH){1'b0}}, irq_enable_high_reg};
        s_axi_rresp <= timer_pkg::RESP_OKAY;
      end
      for (int j = 0; j < NCH; j++) begin
        if (ch_hit(s_axi_araddr, j, timer_pkg::CTRL_OFF)) begin
          s_axi_rdata <= {24'h0, channel_control_reg[j]};
          s_axi_rresp <= timer_pkg::RESP_OKAY;
        end
        if (ch_hit(s_axi_araddr, j, timer_pkg::CMP_OFF)) begin
          s_axi_rdata <= {24'h0, compare_value_reg[j]};
          s_axi_rresp <= timer_pkg::RESP_OKAY;
        end
        if (ch_hit(s_axi_araddr, j, timer_pkg::CNT_OFF)) begin
          s_axi_rdata <= {24'h0, count_reg[j]};
          s_axi_rresp <= timer_pkg::RESP_OKAY;
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: verification/timer_top_sva.sv
// Purpose: Port-level checks for the timer block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every timer_top instance
`timescale 1ns/1ps
module timer_checker #(
  parameter int FC_DIV = 1,
  parameter int FS_DIV = 305
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  divider_out_pin,
  input wire logic [1:0]  match_irq,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_MATCH0_PULSE: assert property (match_irq[0] |=> !match_irq[0] [*3])
    else $error("match pulse on channel 0 too long");
  AST_MATCH1_PULSE: assert property (match_irq[1] |=> !match_irq[1] [*3])
    else $error("match pulse on channel 1 too long");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(|match_irq) || $rose(s_axi_bvalid))
    else $error("interrupt rose without a cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
    else $error("interrupt fell without a bus access");
  AST_PIN0_HOLD: assert property ($changed(divider_out_pin[0])
    |-> $past(match_irq[0]) || $rose(s_axi_bvalid))
    else $error("divider pin 0 moved without match or write");
  AST_PIN1_HOLD: assert property ($changed(divider_out_pin[1])
    |-> $past(match_irq[1]) || $rose(s_axi_bvalid))
    else $error("divider pin 1 moved without match or write");
  AST_RD_TURN: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_TURN: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  cover property (match_irq[0]);
  cover property ($rose(irq));
  cover property ($changed(divider_out_pin[0]));
endmodule

bind timer_top timer_checker #(.FC_DIV(FC_DIV), .FS_DIV(FS_DIV)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .divider_out_pin(divider_out_pin), .match_irq(match_irq), .irq(irq));

// file: verification/event_source.sv
// Purpose: External event source and port latch on the divider pins
// Assumes: Driven just after rising edges of aclk
// Notes:   Pins idle high between bursts
`timescale 1ns/1ps
module event_source (
  input  wire logic       aclk,
  input  wire logic [1:0] divider_out_pin,
  output logic [1:0]      event_in_pin,
  output logic [1:0]      pad_level
);
  logic [1:0] port_latch = 2'h3;
  initial event_in_pin = 2'h3;
  assign pad_level = divider_out_pin & port_latch;

  // Each level held three cycles
  task automatic send_falls(input int ch, input int k);
    repeat (k) begin
      @(posedge aclk);
      event_in_pin[ch] <= 1'b0;
      repeat (3) @(posedge aclk);
      event_in_pin[ch] <= 1'b1;
      repeat (2) @(posedge aclk);
    end
  endtask
endmodule

// file: verification/eight_bit_timer_event_divider_test.sv
// Purpose: Self-checking bench for the timer block
// Assumes: FC_DIV 1, FS_DIV 2
// Notes:   Random compare values from a fixed seed
`timescale 1ns/1ps
module eight_bit_timer_event_divider_test;
  localparam int FC = 1;
  localparam int FS = 2;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [5:0]  s_axi_araddr = 6'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, event_in_pin, divider_out_pin, match_irq;
  logic [31:0] s_axi_rdata;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          ev_cnt = 0;

  timer_top #(.FC_DIV(FC), .FS_DIV(FS)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .event_in_pin(event_in_pin),
    .divider_out_pin(divider_out_pin), .match_irq(match_irq), .irq(irq));
  event_source i_src (.aclk(aclk), .divider_out_pin(divider_out_pin),
    .event_in_pin(event_in_pin), .pad_level());

  initial begin
    forever #50 aclk = ~aclk;
  end

  // Sampled mid-period, where combinational outputs have settled
  always @(negedge aclk) begin
    cyc++;
    if (match_irq[1] === 1'b1) ev_cnt++;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    bit b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Handshakes judged on values that stand at the next rising edge
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic wrc(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    bit rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
  endtask

  function automatic int tlen(logic [2:0] ck, logic [1:0] cfg);
    if (ck == timer_pkg::CK_SLOW_TAP && cfg != 2'h0) return 8 * FS;
    case (ck)
      timer_pkg::CK_SLOW_TAP: return 2048 * FC;
      timer_pkg::CK_DIV7:     return 128 * FC;
      timer_pkg::CK_DIV5:     return 32 * FC;
      default:                return 8 * FC;
    endcase
  endfunction

  task automatic gap(input int ch, output int n);
    do @(negedge aclk); while (match_irq[ch] !== 1'b1);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (match_irq[ch] !== 1'b1);
  endtask

  task automatic pin_run(output int n);
    logic p;
    p = divider_out_pin[0];
    do @(negedge aclk); while (divider_out_pin[0] === p);
    p = divider_out_pin[0];
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (divider_out_pin[0] === p);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    logic [5:0]  adr [6];
    logic [7:0]  rst [6];
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  ck;
    logic [1:0]  cfg;
    int          m;
    int          n;
    adr = '{6'h00, 6'h04, 6'h08, 6'h20, 6'h24, 6'h28};
    rst = '{timer_pkg::CTRL_RST, timer_pkg::CMP_RST, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(10));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk(divider_out_pin, 2'h3);
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d, r);
      chk(d, {24'h0, rst[i]});
    end
    rd(6'h2c, d, r);
    chk(r, timer_pkg::RESP_SLVERR);
    wr(6'h2c, 8'h01, r);
    chk(r, timer_pkg::RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      ck = (i < 4) ? 3'(i) : 3'h0;
      cfg = (i < 4) ? 2'h0 : 2'(i - 3);
      m = $urandom_range(2, 1);
      wrc(6'h20, {6'h0, cfg});
      wrc(6'h04, 8'(m));
      wrc(6'h00, {1'b0, ck, 4'h0});
      wrc(6'h00, {1'b0, ck, 4'h8});
      gap(0, n);
      chk(n, m * tlen(ck, cfg));
      wrc(6'h00, 8'h00);
    end
    wrc(6'h20, 8'h00);
    chk(irq, 1'b0);
    wrc(6'h28, 8'h01);
    chk(irq, 1'b1);
    rd(6'h24, d, r);
    chk(d, 32'h1);
    rd(6'h24, d, r);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    m = $urandom_range(5, 1);
    wrc(6'h14, 8'(m));
    wrc(6'h10, 8'h40);
    wrc(6'h10, 8'h48);
    ev_cnt = 0;
    i_src.send_falls(1, 2 * m + 1);
    repeat (10) @(posedge aclk);
    chk(ev_cnt, (m == 1) ? 3 : 2);
    rd(6'h18, d, r);
    chk(d, (m == 1) ? 32'h0 : 32'h1);
    chk(divider_out_pin[1], 1'b1);
    m = $urandom_range(4, 1);
    wrc(6'h04, 8'(m));
    wrc(6'h00, 8'h31);
    wrc(6'h00, 8'h39);
    chk(divider_out_pin[0], 1'b1);
    pin_run(n);
    chk(n, m * 8);
    pin_run(n);
    chk(n, m * 8);
    wrc(6'h00, 8'h31);
    d = {31'h0, divider_out_pin[0]};
    repeat (40) @(posedge aclk);
    chk(divider_out_pin[0], d[0]);
    wrc(6'h00, 8'hb1);
    chk(divider_out_pin[0], 1'b0);
    wrc(6'h00, 8'h31);
    chk(divider_out_pin[0], 1'b1);
    complete_run();
  end
endmodule
